//--- core/ecd_arg_decode.sv
`timescale 1ns/1ps
module ecd_arg_decode (
  // erase argument and enables
  input  wire logic [31:0]    arg,
  input  wire logic           gcAllowed,
  input  wire logic           secAllowed,
  // decoded operation
  output ecd_pkg::ecd_op_t    opKind,
  output logic                secure,
  output logic                forceGc,
  output logic                argErr
);

  logic trimBit;
  logic discBit;

  assign trimBit = arg[ecd_pkg::ARG_TRIM_BIT];
  assign discBit = arg[ecd_pkg::ARG_DISCARD_BIT];

  always_comb begin
    if (trimBit && discBit) begin
      opKind = ecd_pkg::ECD_OP_DISCARD;
    end else if (trimBit) begin
      opKind = ecd_pkg::ECD_OP_TRIM;
    end else begin
      opKind = ecd_pkg::ECD_OP_ERASE;
    end
  end

  // optional requests only honoured when enabled; never an error
  assign forceGc = arg[ecd_pkg::ARG_GC_BIT] & gcAllowed;
  assign secure  = arg[ecd_pkg::ARG_SECURE_BIT] & secAllowed;

  // must-be-zero fields or discard without trim are undefined
  assign argErr = (|(arg & ecd_pkg::ARG_ZERO_MASK)) | (discBit & ~trimBit);

endmodule : ecd_arg_decode

//--- core/ecd_erase_decoder.sv
`timescale 1ns/1ps
// Overview of operation
// - commands 32 to 34 and 37 are reserved; they carry no erase meaning.
// - command 35 latches its argument as the first erase group address.
// - command 36 latches its argument as the last erase group address.
// - addresses are bytes for small media, 512-byte sectors for large media.
// - low address bits below the erase group size are ignored, rounding down.
// - command 38 erases the selected range and answers with a busy response.
// - all argument bits zero selects a plain erase of the erase groups.
// - bit 0 set with bit 1 clear selects trim of the sectors.
// - bits 0 and 1 both set select discard of the sectors.
// - setting bits 31 or 15 never raises an error.
// - any other argument combination reports an error.
// - forced garbage collect in bit 15 needs configuration bit 4 set.
// - secure request in bit 31 needs configuration bit 0 set.
module ecd_erase_decoder (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           nrst,
  // wishbone slave
  input  wire logic [7:0]     adr_i,
  input  wire logic [31:0]    dat_i,
  input  wire logic [3:0]     sel_i,
  input  wire logic           we_i,
  input  wire logic           cyc_i,
  input  wire logic           stb_i,
  output logic      [31:0]    dat_o,
  output logic                ack_o,
  // interrupt
  output logic                irq,
  // command from the host link
  input  wire logic           cmdValid,
  input  wire logic [5:0]     cmdIndex,
  input  wire logic [31:0]    cmdArg,
  // response to the host link
  output logic                rspValid,
  output logic                rspBusy,
  output logic                rspArgErr,
  output logic                rspSeqErr,
  // request to the media back end
  output logic                opStart,
  output logic      [1:0]     opKind,
  output logic                opSecure,
  output logic                opForceGc,
  output logic      [31:0]    opFirst,
  output logic      [31:0]    opLast,
  input  wire logic           opDone
);

  typedef struct packed {
    ecd_pkg::ecd_state_t      state;
    logic                     highCap;
    logic [3:0]               grpShift;
    logic [7:0]               cfgByte;
    logic [ecd_pkg::ST_W-1:0] status;
    logic [ecd_pkg::ST_W-1:0] mask;
    logic [31:0]              firstAddr;
    logic [31:0]              lastAddr;
    logic                     firstValid;
    logic                     lastValid;
    logic [31:0]              lastArg;
    logic [15:0]              doneCount;
    logic                     ack;
    logic [31:0]              datO;
    logic                     irq;
    logic                     rspValid;
    logic                     rspBusy;
    logic                     rspArgErr;
    logic                     rspSeqErr;
    logic                     opStart;
    logic [1:0]               opKind;
    logic                     opSecure;
    logic                     opForceGc;
    logic [31:0]              opFirst;
    logic [31:0]              opLast;
  } ecd_core_t;

  ecd_core_t                  core_r;
  ecd_core_t                  core_nxt;

  // decoded erase argument
  ecd_pkg::ecd_op_t           decKind;
  logic                       decSecure;
  logic                       decForceGc;
  logic                       decArgErr;

  // bus access qualifiers
  logic                       busReq;
  logic                       busWr;
  logic [ecd_pkg::ST_W-1:0]   stSet;
  logic [ecd_pkg::ST_W-1:0]   stClr;
  logic [31:0]                grpAddr;
  logic                       rsvCmd;
  logic                       cmdIdle;
  logic                       isErase;
  logic                       rangeOk;
  logic [ecd_pkg::ST_W-1:0]   stNext;

  ecd_arg_decode u_arg_decode (
    .arg        (cmdArg),
    .gcAllowed  (core_r.cfgByte[ecd_pkg::CFG_GC_EN_BIT]),
    .secAllowed (core_r.cfgByte[ecd_pkg::CFG_SEC_EN_BIT]),
    .opKind     (decKind),
    .secure     (decSecure),
    .forceGc    (decForceGc),
    .argErr     (decArgErr)
  );

  // byte or sector address to group-aligned sector address
  function automatic logic [31:0] to_group(
    input logic [31:0] addr,
    input logic        hc,
    input logic [3:0]  sh
  );
    logic [31:0] sector;
    logic [31:0] keep;
    sector = hc ? addr : (addr >> ecd_pkg::SECTOR_SHIFT);
    keep   = ~((32'h1 << sh) - 32'h1);
    return sector & keep;
  endfunction : to_group

  assign busReq  = cyc_i & stb_i & ~core_r.ack;
  // a write lands on the edge at which the master sees ack
  assign busWr   = cyc_i & stb_i & we_i & core_r.ack;
  assign grpAddr = to_group(cmdArg, core_r.highCap, core_r.grpShift);

  // reserved indexes are recognised only to be refused
  assign rsvCmd = cmdValid &&
                  (((cmdIndex >= ecd_pkg::CMD_RSV_LO) && (cmdIndex <= ecd_pkg::CMD_RSV_HI)) ||
                   (cmdIndex == ecd_pkg::CMD_RSV_ALT));

  // range and erase commands are only taken while idle
  assign cmdIdle = cmdValid && !rsvCmd && (core_r.state == ecd_pkg::ECD_IDLE);
  assign isErase = cmdIdle && (cmdIndex == ecd_pkg::CMD_ERASE);
  assign rangeOk = core_r.firstValid && core_r.lastValid &&
                   (core_r.lastAddr >= core_r.firstAddr);

  // event strobes into the sticky status
  assign stSet[ecd_pkg::ST_DONE]    = (core_r.state == ecd_pkg::ECD_BUSY) && opDone;
  assign stSet[ecd_pkg::ST_ARG_ERR] = isErase && decArgErr;
  assign stSet[ecd_pkg::ST_SEQ_ERR] = isErase && !decArgErr && !rangeOk;
  assign stSet[ecd_pkg::ST_RSV_CMD] = rsvCmd;
  assign stClr = (busWr && sel_i[0] && (adr_i == ecd_pkg::REG_STATUS)) ?
                 dat_i[ecd_pkg::ST_W-1:0] : '0;

  // sticky status: a new event wins over a clear in the same cycle
  for (genvar b = 0; b < ecd_pkg::ST_W; b++) begin : g_status
    assign stNext[b] = stSet[b] | (core_r.status[b] & ~stClr[b]);
  end

  always_comb begin
    core_nxt = core_r;

    // one-cycle pulses
    core_nxt.rspValid  = 1'b0;
    core_nxt.opStart   = 1'b0;
    core_nxt.ack       = busReq;
    core_nxt.datO      = 32'h0;

    // command handling
    if (cmdIdle) begin
      case (cmdIndex)
        ecd_pkg::CMD_GRP_START: begin
          core_nxt.firstAddr  = grpAddr;
          core_nxt.firstValid = 1'b1;
          core_nxt.rspValid   = 1'b1;
          core_nxt.rspArgErr  = 1'b0;
          core_nxt.rspSeqErr  = 1'b0;
        end
        ecd_pkg::CMD_GRP_END: begin
          core_nxt.lastAddr  = grpAddr;
          core_nxt.lastValid = 1'b1;
          core_nxt.rspValid  = 1'b1;
          core_nxt.rspArgErr = 1'b0;
          core_nxt.rspSeqErr = 1'b0;
        end
        ecd_pkg::CMD_ERASE: begin
          core_nxt.lastArg    = cmdArg;
          core_nxt.rspValid   = 1'b1;
          core_nxt.firstValid = 1'b0;
          core_nxt.lastValid  = 1'b0;
          core_nxt.rspArgErr  = decArgErr;
          core_nxt.rspSeqErr  = 1'b0;
          if (decArgErr) begin
            core_nxt.opStart = 1'b0;
          end else if (!rangeOk) begin
            core_nxt.rspSeqErr = 1'b1;
          end else begin
            core_nxt.opStart   = 1'b1;
            core_nxt.opKind    = decKind;
            core_nxt.opSecure  = decSecure;
            core_nxt.opForceGc = decForceGc;
            core_nxt.opFirst   = core_r.firstAddr;
            core_nxt.opLast    = core_r.lastAddr;
            core_nxt.rspBusy   = 1'b1;
            core_nxt.state     = ecd_pkg::ECD_BUSY;
          end
        end
        default: begin
        end
      endcase
    end

    // busy holds until the back end finishes
    case (core_r.state)
      ecd_pkg::ECD_IDLE: begin
      end
      ecd_pkg::ECD_BUSY: begin
        if (opDone) begin
          core_nxt.rspBusy   = 1'b0;
          core_nxt.state     = ecd_pkg::ECD_IDLE;
          core_nxt.doneCount = core_r.doneCount + 16'h1;
        end
      end
      default: begin
        core_nxt.state   = ecd_pkg::ECD_IDLE;
        core_nxt.rspBusy = 1'b0;
      end
    endcase

    // register writes
    if (busWr && sel_i[0]) begin
      case (adr_i)
        ecd_pkg::REG_CTRL: begin
          core_nxt.highCap  = dat_i[ecd_pkg::CTRL_HC_BIT];
          core_nxt.grpShift = dat_i[ecd_pkg::CTRL_SH_LSB +: 4];
        end
        ecd_pkg::REG_CFG: begin
          core_nxt.cfgByte = dat_i[7:0];
        end
        ecd_pkg::REG_MASK: begin
          core_nxt.mask = dat_i[ecd_pkg::ST_W-1:0];
        end
        default: begin
        end
      endcase
    end

    // register reads
    if (busReq && !we_i) begin
      case (adr_i)
        ecd_pkg::REG_CTRL: begin
          core_nxt.datO[ecd_pkg::CTRL_HC_BIT]     = core_r.highCap;
          core_nxt.datO[ecd_pkg::CTRL_SH_LSB +: 4] = core_r.grpShift;
        end
        ecd_pkg::REG_CFG: begin
          core_nxt.datO[7:0] = core_r.cfgByte;
        end
        ecd_pkg::REG_STATUS: begin
          core_nxt.datO[ecd_pkg::ST_W-1:0] = core_r.status;
        end
        ecd_pkg::REG_MASK: begin
          core_nxt.datO[ecd_pkg::ST_W-1:0] = core_r.mask;
        end
        ecd_pkg::REG_FIRST: begin
          core_nxt.datO = core_r.firstAddr;
        end
        ecd_pkg::REG_LAST: begin
          core_nxt.datO = core_r.lastAddr;
        end
        ecd_pkg::REG_STATE: begin
          core_nxt.datO[0] = (core_r.state == ecd_pkg::ECD_BUSY);
          core_nxt.datO[1] = core_r.firstValid;
          core_nxt.datO[2] = core_r.lastValid;
        end
        ecd_pkg::REG_ARG: begin
          core_nxt.datO = core_r.lastArg;
        end
        ecd_pkg::REG_COUNT: begin
          core_nxt.datO[15:0] = core_r.doneCount;
        end
        default: begin
        end
      endcase
    end

    // sticky status and level interrupt
    core_nxt.status = stNext;
    core_nxt.irq    = |(core_nxt.status & core_nxt.mask);
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      core_r            <= '0;
      core_r.state      <= ecd_pkg::ECD_IDLE;
      core_r.grpShift   <= ecd_pkg::GRP_SHIFT_RST;
      core_r.cfgByte    <= ecd_pkg::CFG_RST;
      core_r.opKind     <= ecd_pkg::ECD_OP_ERASE;
    end else begin
      core_r <= core_nxt;
    end
  end

  assign dat_o     = core_r.datO;
  assign ack_o     = core_r.ack;
  assign irq       = core_r.irq;
  assign rspValid  = core_r.rspValid;
  assign rspBusy   = core_r.rspBusy;
  assign rspArgErr = core_r.rspArgErr;
  assign rspSeqErr = core_r.rspSeqErr;
  assign opStart   = core_r.opStart;
  assign opKind    = core_r.opKind;
  assign opSecure  = core_r.opSecure;
  assign opForceGc = core_r.opForceGc;
  assign opFirst   = core_r.opFirst;
  assign opLast    = core_r.opLast;

endmodule : ecd_erase_decoder

//--- core/ecd_pkg.sv
package ecd_pkg;

  // command indexes of the erase class
  localparam logic [5:0] CMD_GRP_START = 6'h23;
  localparam logic [5:0] CMD_GRP_END   = 6'h24;
  localparam logic [5:0] CMD_ERASE     = 6'h26;
  localparam logic [5:0] CMD_RSV_LO    = 6'h20;
  localparam logic [5:0] CMD_RSV_HI    = 6'h22;
  localparam logic [5:0] CMD_RSV_ALT   = 6'h25;

  // erase argument layout
  localparam int unsigned  ARG_TRIM_BIT    = 0;
  localparam int unsigned  ARG_DISCARD_BIT = 1;
  localparam int unsigned  ARG_GC_BIT      = 15;
  localparam int unsigned  ARG_SECURE_BIT  = 31;
  localparam logic [31:0]  ARG_ZERO_MASK   = 32'h7fff7ffc;

  // configuration byte 231 layout
  localparam int unsigned  CFG_SEC_EN_BIT = 0;
  localparam int unsigned  CFG_GC_EN_BIT  = 4;

  // byte address to 512-byte sector
  localparam int unsigned  SECTOR_SHIFT = 9;

  // register byte offsets
  localparam logic [7:0]   REG_CTRL   = 8'h00;
  localparam logic [7:0]   REG_CFG    = 8'h04;
  localparam logic [7:0]   REG_STATUS = 8'h08;
  localparam logic [7:0]   REG_MASK   = 8'h0c;
  localparam logic [7:0]   REG_FIRST  = 8'h10;
  localparam logic [7:0]   REG_LAST   = 8'h14;
  localparam logic [7:0]   REG_STATE  = 8'h18;
  localparam logic [7:0]   REG_ARG    = 8'h1c;
  localparam logic [7:0]   REG_COUNT  = 8'h20;

  // control fields and reset values
  localparam int unsigned  CTRL_HC_BIT   = 0;
  localparam int unsigned  CTRL_SH_LSB   = 4;
  localparam logic [3:0]   GRP_SHIFT_RST = 4'h0;
  localparam logic [7:0]   CFG_RST       = 8'h00;

  // sticky status bits
  localparam int unsigned  ST_W       = 4;
  localparam int unsigned  ST_DONE    = 0;
  localparam int unsigned  ST_ARG_ERR = 1;
  localparam int unsigned  ST_SEQ_ERR = 2;
  localparam int unsigned  ST_RSV_CMD = 3;

  typedef enum logic [1:0] {
    ECD_IDLE = 2'b00,
    ECD_BUSY = 2'b01
  } ecd_state_t;

  typedef enum logic [1:0] {
    ECD_OP_ERASE   = 2'h0,
    ECD_OP_TRIM    = 2'h1,
    ECD_OP_DISCARD = 2'h3
  } ecd_op_t;

endpackage : ecd_pkg

//--- testbench/ecd_erase_checker.sv
`timescale 1ns/1ps
module ecd_erase_checker (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // register bus
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        ack_o,
  // command and response
  input  wire logic        cmdValid,
  input  wire logic [5:0]  cmdIndex,
  input  wire logic [31:0] cmdArg,
  input  wire logic        rspValid,
  input  wire logic        rspBusy,
  input  wire logic        rspArgErr,
  input  wire logic        rspSeqErr,
  // back end
  input  wire logic        opStart,
  input  wire logic [1:0]  opKind,
  input  wire logic        opSecure,
  input  wire logic        opForceGc,
  input  wire logic        opDone
);
  wire logic rsv = cmdValid && (cmdIndex inside {[ecd_pkg::CMD_RSV_LO:ecd_pkg::CMD_RSV_HI],
                                                 ecd_pkg::CMD_RSV_ALT});
  wire logic rng = cmdValid && !rspBusy && (cmdIndex == ecd_pkg::CMD_GRP_START ||
                                            cmdIndex == ecd_pkg::CMD_GRP_END);
  wire logic ers = cmdValid && !rspBusy && cmdIndex == ecd_pkg::CMD_ERASE;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  wb_ack_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o)
    else $error("bus access not acked for one cycle");
  rsv_cmd_a: assert property (
    rsv |=> !rspValid && !opStart) else $error("reserved command answered");
  range_rsp_a: assert property (
    rng |=> rspValid && !opStart && !rspArgErr && !rspSeqErr) else $error("range answer bad");
  erase_rsp_a: assert property (
    ers |=> rspValid && (opStart == !(rspArgErr || rspSeqErr))) else $error("erase answer bad");
  start_busy_a: assert property (
    opStart |-> rspBusy && $past(cmdIndex) == ecd_pkg::CMD_ERASE) else $error("start not busy");
  busy_hold_a: assert property (
    rspBusy && !opDone |=> rspBusy) else $error("busy dropped early");
  busy_end_a: assert property (
    rspBusy && opDone |=> !rspBusy) else $error("busy held after done");
  op_kind_a: assert property (
    opStart |-> opKind == $past(cmdArg[1:0])) else $error("operation kind wrong");
  sec_bit_a: assert property (
    opStart && opSecure |-> $past(cmdArg[31])) else $error("secure without request");
  gc_bit_a: assert property (
    opStart && opForceGc |-> $past(cmdArg[15])) else $error("collect without request");
endmodule : ecd_erase_checker
bind ecd_erase_decoder ecd_erase_checker u_chk (.clk(clk), .nrst(nrst), .cyc_i(cyc_i),
  .stb_i(stb_i), .ack_o(ack_o), .cmdValid(cmdValid), .cmdIndex(cmdIndex), .cmdArg(cmdArg),
  .rspValid(rspValid), .rspBusy(rspBusy), .rspArgErr(rspArgErr), .rspSeqErr(rspSeqErr),
  .opStart(opStart), .opKind(opKind), .opSecure(opSecure), .opForceGc(opForceGc),
  .opDone(opDone));

//--- testbench/ecd_host_model.sv
`timescale 1ns/1ps
module ecd_host_model (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // request from the bench
  input  wire logic        go,
  input  wire logic [5:0]  goIdx,
  input  wire logic [31:0] goArg,
  // command line toward the device
  output logic             cmdValid,
  output logic      [5:0]  cmdIndex,
  output logic      [31:0] cmdArg
);
  // one-cycle command; idle lines carry the inverse of the last value
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cmdValid <= 1'b0;
      cmdIndex <= 6'h00;
      cmdArg   <= 32'h0;
    end else if (go) begin
      cmdValid <= 1'b1;
      cmdIndex <= goIdx;
      cmdArg   <= goArg;
    end else begin
      cmdValid <= 1'b0;
      cmdIndex <= ~cmdIndex;
      cmdArg   <= ~cmdArg;
    end
  end
endmodule : ecd_host_model

//--- testbench/test_erase_command_decoder.sv
`timescale 1ns/1ps
module test_erase_command_decoder;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic        go = 1'b0;
  logic        opDone = 1'b0;
  logic        hc = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [5:0]  goIdx = 6'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] goArg = 32'h0;
  logic [31:0] rdat, rd, cmdArg, opFirst, opLast;
  logic [5:0]  cmdIndex;
  logic [1:0]  opKind;
  logic        ack, irq, cmdValid, rspValid, rspBusy, rspArgErr, rspSeqErr;
  logic        opStart, opSecure, opForceGc;
  int          err_total = 0;
  int          checked = 0;
  int          cycN = 0;
  wire logic [4:0]  rs = {rspValid, rspBusy, rspArgErr, rspSeqErr, opStart};
  wire logic [3:0]  op = {opKind, opSecure, opForceGc};
  localparam logic [31:0] F = 32'h0001_2345;
  localparam logic [31:0] L = 32'h0004_1fff;
  logic [31:0] args [8] = '{32'h1, 32'h3, 32'h2, 32'h10000, 32'h4, 32'h80008000,
                            32'h80008001, 32'h8003};
  logic [4:0]  rsx [8] = '{5'h19, 5'h19, 5'h14, 5'h14, 5'h14, 5'h19, 5'h19, 5'h19};
  logic [3:0]  opx [8] = '{4'h4, 4'hc, 4'h0, 4'h0, 4'h0, 4'h0, 4'h7, 4'hd};
  logic [7:0]  rz [5] = '{ecd_pkg::REG_CTRL, ecd_pkg::REG_CFG, ecd_pkg::REG_STATUS,
                          ecd_pkg::REG_MASK, 8'h40};
  logic [5:0]  rv [4] = '{ecd_pkg::CMD_RSV_LO, 6'h21, ecd_pkg::CMD_RSV_HI, ecd_pkg::CMD_RSV_ALT};

  always #5 clk = ~clk;

  ecd_erase_decoder DUT (.clk(clk), .nrst(nrst), .adr_i(adr), .dat_i(wdat), .sel_i(4'h1),
    .we_i(we), .cyc_i(cyc), .stb_i(cyc), .dat_o(rdat), .ack_o(ack), .irq(irq),
    .cmdValid(cmdValid), .cmdIndex(cmdIndex), .cmdArg(cmdArg), .rspValid(rspValid),
    .rspBusy(rspBusy), .rspArgErr(rspArgErr), .rspSeqErr(rspSeqErr), .opStart(opStart),
    .opKind(opKind), .opSecure(opSecure), .opForceGc(opForceGc), .opFirst(opFirst),
    .opLast(opLast), .opDone(opDone));

  ecd_host_model u_host (.clk(clk), .nrst(nrst), .go(go), .goIdx(goIdx), .goArg(goArg),
    .cmdValid(cmdValid), .cmdIndex(cmdIndex), .cmdArg(cmdArg));

  function automatic logic [31:0] sect(input logic [31:0] a);
    logic [31:0] s;
    s = hc ? a : a >> 9;
    return s & ~32'h7;
  endfunction : sect

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    if (err_total == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : stop_test

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
  endtask : wb

  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle

  task automatic send(input logic [5:0] i, input logic [31:0] a);
    @(posedge clk);
    go <= 1'b1;
    goIdx <= i;
    goArg <= a;
    @(posedge clk);
    go <= 1'b0;
    settle();
  endtask : send

  task automatic erase(input logic [31:0] a, input logic [4:0] r, input logic [3:0] o);
    send(ecd_pkg::CMD_GRP_START, F);
    chk(32'(rs), 32'h10);
    send(ecd_pkg::CMD_GRP_END, L);
    chk(32'(rs), 32'h10);
    send(ecd_pkg::CMD_ERASE, a);
    chk(32'(rs), 32'(r));
    if (r[0]) begin
      chk(32'(op), 32'(o));
      chk(opFirst, sect(F));
      chk(opLast, sect(L));
      repeat (4) @(posedge clk);
      opDone <= 1'b1;
      #1;
      chk(32'(rspBusy), 32'h1);
      @(posedge clk);
      opDone <= 1'b0;
      #1;
      chk(32'(rspBusy), 32'h0);
    end
  endtask : erase

  always @(posedge clk) begin
    cycN++;
    if (cycN == 20000) begin
      err_total++;
      $display("[ERR] %0t timeout", $time);
      stop_test();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    foreach (rz[i]) begin
      wb(1'b0, rz[i], 32'h0);
      chk(rd, 32'h0);
    end
    wb(1'b1, ecd_pkg::REG_MASK, 32'h1);
    wb(1'b1, ecd_pkg::REG_CTRL, 32'h30);
    erase(32'h0, 5'h19, 4'h0);
    settle();
    chk(32'(irq), 32'h1);
    wb(1'b1, ecd_pkg::REG_STATUS, 32'h1);
    settle();
    chk(32'(irq), 32'h0);
    wb(1'b1, ecd_pkg::REG_MASK, 32'h0);
    foreach (args[i]) begin
      if (i == 6) wb(1'b1, ecd_pkg::REG_CFG, 32'h11);
      erase(args[i], rsx[i], opx[i]);
    end
    send(ecd_pkg::CMD_ERASE, 32'h0);
    chk(32'(rs), 32'h12);
    foreach (rv[i]) begin
      send(rv[i], 32'h0);
      chk(32'({rs[4], rs[0]}), 32'h0);
    end
    wb(1'b0, ecd_pkg::REG_FIRST, 32'h0);
    chk(rd, sect(F));
    wb(1'b0, ecd_pkg::REG_STATUS, 32'h0);
    chk(rd, 32'hf);
    chk(32'(irq), 32'h0);
    wb(1'b1, ecd_pkg::REG_MASK, 32'hf);
    settle();
    chk(32'(irq), 32'h1);
    wb(1'b1, ecd_pkg::REG_STATUS, 32'hf);
    settle();
    chk(32'(irq), 32'h0);
    hc = 1'b1;
    wb(1'b1, ecd_pkg::REG_CTRL, 32'h31);
    erase(32'h1, 5'h19, 4'h4);
    wb(1'b0, ecd_pkg::REG_LAST, 32'h0);
    chk(rd, sect(L));
    wb(1'b0, ecd_pkg::REG_ARG, 32'h0);
    chk(rd, 32'h1);
    wb(1'b0, ecd_pkg::REG_COUNT, 32'h0);
    chk(rd, 32'h7);
    wb(1'b0, ecd_pkg::REG_STATE, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h40, 32'hffff_ffff);
    wb(1'b0, 8'h40, 32'h0);
    chk(rd, 32'h0);
    stop_test();
  end
endmodule : test_erase_command_decoder
